/* rtl/sbac_arbiter.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module sbac_arbiter #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // serial side
  input  wire logic              i_rx_pin,
  input  wire logic              i_internal_transmit_out,
  input  wire logic              i_prescaler_tick,
  output logic                   o_tx_pin,
  // interrupt
  output logic                   o_irq
);
  initial begin
    if (ADDR_W < 4) begin
      $error("address width too small");
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [1:0] rx_sync_reg;
  logic [1:0] txi_sync_reg;
  logic       rx_d_reg;
  logic       txi_d_reg;
  logic       pre_half_reg;
  logic [1:0] bus_div_reg;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_sync_reg  <= 2'h3;
      txi_sync_reg <= 2'h3;
      rx_d_reg     <= 1'b1;
      txi_d_reg    <= 1'b1;
    end else begin
      rx_sync_reg  <= {rx_sync_reg[0], i_rx_pin};
      txi_sync_reg <= {txi_sync_reg[0], i_internal_transmit_out};
      rx_d_reg     <= rx_sync_reg[1];
      txi_d_reg    <= txi_sync_reg[1];
    end
  end
  wire rx_s     = rx_sync_reg[1];
  wire txi_s    = txi_sync_reg[1];
  wire rx_fall  = rx_d_reg & ~rx_s;
  wire rx_rise  = ~rx_d_reg & rx_s;
  wire txi_rise = ~txi_d_reg & txi_s;
  wire txi_fall = txi_d_reg & ~txi_s;

  // ==========================================================
  // control state
  logic [1:0] mode_reg;
  logic       clk_sel_reg;
  logic       lost_reg;
  logic       done_reg;
  logic       run_reg;
  logic       ovf_reg;
  logic [8:0] count_reg;
  logic       armed_reg;
  logic [2:0] irq_en_reg;
  logic [2:0] irq_st_reg;

  wire bus_tick = (bus_div_reg == sbac_pkg::SBAC_BUS_DIV_LAST);
  wire pre_tick = i_prescaler_tick & pre_half_reg;
  wire cnt_tick = clk_sel_reg ? pre_tick : bus_tick;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bus_div_reg  <= 2'h0;
      pre_half_reg <= 1'b0;
    end else begin
      bus_div_reg  <= bus_div_reg + 2'h1;
      pre_half_reg <= i_prescaler_tick ? ~pre_half_reg : pre_half_reg;
    end
  end

  // ==========================================================
  // axi4-lite slave: write takes both channels together
  wire wr_go = i_awvalid & i_wvalid & ~o_bvalid;
  wire rd_go = i_arvalid & ~o_rvalid;
  wire [3:0] wofs = i_awaddr[3:0];
  wire [3:0] rofs = i_araddr[3:0];
  wire wr_ctl = wr_go & (wofs == sbac_pkg::SBAC_OFS_CONTROL) & i_wstrb[0];
  wire wr_ien = wr_go & (wofs == sbac_pkg::SBAC_OFS_ENABLE) & i_wstrb[1];
  wire wr_clr = wr_go & (wofs == sbac_pkg::SBAC_OFS_CLEAR) & i_wstrb[0];
  wire wr_ok  = (wofs == sbac_pkg::SBAC_OFS_CONTROL) | (wofs == sbac_pkg::SBAC_OFS_CLEAR);
  wire rd_ok  = (rofs == sbac_pkg::SBAC_OFS_CONTROL) | (rofs == sbac_pkg::SBAC_OFS_COUNT)
              | (rofs == sbac_pkg::SBAC_OFS_STATUS);
  wire [1:0] new_mode = i_wdata[sbac_pkg::SBAC_B_MODE1:sbac_pkg::SBAC_B_MODE0];
  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign o_arready = rd_go;

  // ==========================================================
  // counter behaviour
  wire idle      = (mode_reg == sbac_pkg::SBAC_MODE_IDLE);
  wire meas      = (mode_reg == sbac_pkg::SBAC_MODE_MEASURE);
  wire arb       = (mode_reg == sbac_pkg::SBAC_MODE_ARB);
  wire [8:0] smp = clk_sel_reg ? sbac_pkg::SBAC_ARB_PT_PRE : sbac_pkg::SBAC_ARB_PT_BUS;
  wire [9:0] inc = {1'b0, count_reg} + 10'h001;
  // select 0: falling edge, select 1: low receive line starts when not yet done
  wire m_start0  = meas & ~clk_sel_reg & ~run_reg & ~done_reg & rx_fall;
  wire m_start1  = meas & clk_sel_reg & ~run_reg & ~done_reg & ~rx_s;
  // second falling edge / rising edge stop
  wire m_stop    = meas & run_reg & (clk_sel_reg ? rx_rise : rx_fall);
  wire arb_hit   = arb & run_reg & cnt_tick & (count_reg == smp - 9'h001);
  wire lost_set  = arb_hit & ~rx_s;
  wire ovf_set   = run_reg & cnt_tick & inc[9] & ~m_stop;
  sbac_pkg::sbac_evt_t evt;
  assign evt.lost = lost_set;
  assign evt.ovf  = ovf_set;
  assign evt.done = m_stop;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_reg    <= sbac_pkg::SBAC_MODE_IDLE;
      clk_sel_reg <= 1'b0;
      lost_reg    <= 1'b0;
      done_reg    <= 1'b0;
      run_reg     <= 1'b0;
      ovf_reg     <= 1'b0;
      count_reg   <= 9'h000;
      armed_reg   <= 1'b0;
    end else begin
      if (wr_ctl) begin
        mode_reg    <= new_mode;
        clk_sel_reg <= i_wdata[sbac_pkg::SBAC_B_CLKS];
      end
      // lost cleared by zero upper mode; event wins
      if (lost_set) begin
        lost_reg <= 1'b1;
      end else if (wr_ctl & ~new_mode[1]) begin
        lost_reg <= 1'b0;
      end
      // sticky flags, set wins over clear
      done_reg <= m_stop | (done_reg & ~wr_ctl);
      ovf_reg  <= ovf_set | (ovf_reg & ~wr_ctl);
      // control write or idle clears counter
      if (wr_ctl | idle) begin
        count_reg <= 9'h000;
        run_reg   <= 1'b0;
        armed_reg <= 1'b0;
      end else if (meas) begin
        if (m_start0 | m_start1) begin
          run_reg <= 1'b1;
        end else if (m_stop) begin
          run_reg <= 1'b0;
        end else if (run_reg & cnt_tick) begin
          count_reg <= inc[8:0];
        end
      end else if (arb) begin
        if (txi_rise) begin
          count_reg <= 9'h000;
          run_reg   <= 1'b1;
          armed_reg <= 1'b1;
        // transmit low before loss: reset and wait
        end else if (txi_fall & ~lost_reg) begin
          count_reg <= 9'h000;
          run_reg   <= 1'b0;
          armed_reg <= 1'b0;
        end else if (arb_hit) begin
          count_reg <= smp;
          run_reg   <= 1'b0;
        end else if (run_reg & cnt_tick & armed_reg) begin
          count_reg <= inc[8:0];
        end
      end else begin
        run_reg <= 1'b0;
      end
    end
  end

  // force transmit pin high while lost
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_pin <= 1'b1;
    end else begin
      o_tx_pin <= lost_reg | txi_s; // synchronised transmit
    end
  end

  // ==========================================================
  // interrupts: sticky status, enable, write-one clear
  wire [2:0] clr_bits = wr_clr ? i_wdata[2:0] : 3'h0;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_st_reg <= sbac_pkg::SBAC_IRQ_RESET;
      irq_en_reg <= sbac_pkg::SBAC_IRQ_RESET;
    end else begin
      irq_st_reg <= evt | (irq_st_reg & ~clr_bits);
      if (wr_ien) begin
        irq_en_reg <= i_wdata[sbac_pkg::SBAC_B_IEN +: 3];
      end
    end
  end
  assign o_irq = |(irq_st_reg & irq_en_reg);

  // ==========================================================
  // read data and responses
  wire [31:0] ctl_word = {20'h0, 1'b0, irq_en_reg, mode_reg, lost_reg, clk_sel_reg,
                          done_reg, run_reg, ovf_reg, count_reg[8]};
  wire [31:0] rd_mux = (rofs == sbac_pkg::SBAC_OFS_CONTROL) ? ctl_word :
                       (rofs == sbac_pkg::SBAC_OFS_COUNT) ? {24'h0, count_reg[7:0]} :
                       (rofs == sbac_pkg::SBAC_OFS_STATUS) ? {29'h0, irq_st_reg} : 32'h0;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bvalid <= 1'b0;
      o_bresp  <= sbac_pkg::SBAC_RESP_OKAY;
      o_rvalid <= 1'b0;
      o_rresp  <= sbac_pkg::SBAC_RESP_OKAY;
      o_rdata  <= 32'h0;
    end else begin
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_ok ? sbac_pkg::SBAC_RESP_OKAY : sbac_pkg::SBAC_RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (rd_go) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_ok ? rd_mux : 32'h0;
        o_rresp  <= rd_ok ? sbac_pkg::SBAC_RESP_OKAY : sbac_pkg::SBAC_RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_ctl_write;
    wr_ctl;
  endsequence
  a_idle_count_zero: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    idle |=> (count_reg == 9'h000) && !run_reg)
    else $error("counter not held in idle");
  a_write_clears_flags: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    s_ctl_write and !m_stop |=> !done_reg)
    else $error("done not cleared by write");
  a_write_clears_ovf: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    s_ctl_write and !ovf_set |=> !ovf_reg && count_reg == 9'h000)
    else $error("overflow or count not cleared");
  a_lost_forces_tx: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    lost_reg |=> o_tx_pin)
    else $error("transmit not forced high");
  a_lost_on_low_rx: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    arb_hit && !rx_s |=> lost_reg)
    else $error("lost flag not set");
  a_arb_restart: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    arb && txi_rise && !wr_ctl |=> run_reg && count_reg == 9'h000)
    else $error("arbitration counter not restarted");
  a_meas_stop_done: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    m_stop && !wr_ctl |=> done_reg && !run_reg)
    else $error("measurement did not finish");
  a_ovf_sticky: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ovf_reg && !wr_ctl |=> ovf_reg)
    else $error("overflow dropped without write");
  a_msb_readable: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    rd_go && rofs == sbac_pkg::SBAC_OFS_CONTROL |=> o_rdata[0] == $past(count_reg[8]))
    else $error("count msb misread");

  // ==========================================================
  // further checks
  // bus divider: three quiet cycles, then a tick
  sequence s_bus_gap;
    !bus_tick [*3] ##1 bus_tick;
  endsequence
  a_bus_tick_rate: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    bus_tick |=> s_bus_gap)
    else $error("bus tick spacing wrong");
  // count wraps to zero on overflow
  a_count_wraps: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ovf_set |=> count_reg == 9'h000)
    else $error("count did not wrap");
  a_ovf_sets: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ovf_set |=> ovf_reg)
    else $error("overflow flag not set");
  a_mode_stored: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    wr_ctl |=> mode_reg == $past(new_mode))
    else $error("mode not stored");
  a_clksel_stored: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    wr_ctl |=> clk_sel_reg == $past(i_wdata[sbac_pkg::SBAC_B_CLKS]))
    else $error("clock select not stored");
  a_lost_cleared: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    wr_ctl && !new_mode[1] && !lost_set |=> !lost_reg)
    else $error("lost flag not cleared");
  a_lost_sticky: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    lost_reg && !wr_ctl |=> lost_reg)
    else $error("lost flag dropped");
  a_run_stopped: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !meas && !arb |=> !run_reg)
    else $error("running outside active mode");
  a_meas_start_edge: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    m_start0 && !wr_ctl |=> run_reg)
    else $error("edge start missed");
  a_meas_start_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    m_start1 && !wr_ctl |=> run_reg)
    else $error("low start missed");
  a_done_stays_stopped: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    done_reg && meas && !wr_ctl |=> !run_reg)
    else $error("counter restarted after done");
  a_low_readable: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    rd_go && rofs == sbac_pkg::SBAC_OFS_COUNT |=> o_rdata[7:0] == $past(count_reg[7:0]))
    else $error("count low bits misread");
  a_arb_early_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    arb && txi_fall && !lost_reg && !wr_ctl |=> !run_reg && count_reg == 9'h000)
    else $error("early low did not reset");
  // transmit follows core when not lost
  a_tx_follows: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !lost_reg |=> o_tx_pin == $past(txi_s))
    else $error("transmit pin not following");
  a_ovf_status_sticky: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    irq_st_reg[1] && !clr_bits[1] |=> irq_st_reg[1])
    else $error("overflow status dropped");
endmodule

/* rtl/sbac_pkg.sv */
// Operation
// - nine-bit counter plus separate overflow bit
// - two-bit mode: idle, measure, arbitrate, reserved
// - mode zero resets and holds counter idle
// - lost flag cleared writing zero upper mode
// - clock select: prescaler half or bus/4
// - done flag set on finish, write clears
// - running flag shows counter is counting
// - overflow flag set on wrap, write clears
// - count msb readable, control write clears
// - low count bits readable, control write clears
// - select 0: falling edge starts, next stops
// - select 0: running while counting, done second edge
// - select 1: start while receive line low
// - select 1: stop on next rising edge
// - arbitrate: restart on transmit rising edge
// - sample receive at 0x38 or 0x08
// - lost flag forces transmit pin high
// - transmit low before loss resets, waits rise
package sbac_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] SBAC_OFS_CONTROL = 4'h0;
  localparam logic [3:0] SBAC_OFS_COUNT   = 4'h4;
  localparam logic [3:0] SBAC_OFS_STATUS  = 4'h8;
  localparam logic [3:0] SBAC_OFS_CLEAR   = 4'hc;
  localparam logic [3:0] SBAC_OFS_ENABLE  = 4'h0;
  // control field positions
  localparam int SBAC_B_MSB   = 0;
  localparam int SBAC_B_OVF   = 1;
  localparam int SBAC_B_RUN   = 2;
  localparam int SBAC_B_DONE  = 3;
  localparam int SBAC_B_CLKS  = 4;
  localparam int SBAC_B_LOST  = 5;
  localparam int SBAC_B_MODE0 = 6;
  localparam int SBAC_B_MODE1 = 7;
  localparam int SBAC_B_IEN   = 8;
  // modes
  localparam logic [1:0] SBAC_MODE_IDLE    = 2'h0;
  localparam logic [1:0] SBAC_MODE_MEASURE = 2'h1;
  localparam logic [1:0] SBAC_MODE_ARB     = 2'h2;
  // sample points of arbitration
  localparam logic [8:0] SBAC_ARB_PT_BUS = 9'h038;
  localparam logic [8:0] SBAC_ARB_PT_PRE = 9'h008;
  localparam logic [1:0] SBAC_BUS_DIV_LAST = 2'h3;
  localparam logic [2:0] SBAC_IRQ_RESET = 3'h0;
  localparam logic [1:0] SBAC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SBAC_RESP_SLVERR = 2'h2;
  // event word: done, overflow, lost
  typedef struct packed {
    logic lost;
    logic ovf;
    logic done;
  } sbac_evt_t;
endpackage

/* bench/sbac_bus_node.sv */
`timescale 1ns/1ps
// ====================
// other bus nodes: wired-and line, recessive high
module sbac_bus_node #(
  parameter int ECHO = 2
) (
  // clock
  input  wire logic i_clock,
  // bus side
  input  wire logic i_tx_pin,
  input  wire logic i_dominant,
  output logic      o_rx_pin
);
  logic [ECHO-1:0] echo_reg = '1;
  // line delay; pull-up wins unless a node drives low
  always @(posedge i_clock) begin
    echo_reg <= {echo_reg[ECHO-2:0], i_tx_pin & ~i_dominant};
  end
  assign o_rx_pin = echo_reg[ECHO-1];
endmodule

/* bench/sbac_arbiter_tb.sv */
`timescale 1ns/1ps
module sbac_arbiter_tb;
  // ====================
  // signals
  logic        i_clock = 1'h0;
  logic        i_reset_n = 1'h0;
  logic [3:0]  i_awaddr = 4'h0;
  logic [3:0]  i_araddr = 4'h0;
  logic [3:0]  i_wstrb = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_awvalid = 1'h0;
  logic        i_wvalid = 1'h0;
  logic        i_bready = 1'h0;
  logic        i_arvalid = 1'h0;
  logic        i_rready = 1'h0;
  logic        i_internal_transmit_out = 1'h1;
  logic        i_prescaler_tick = 1'h0;
  logic        i_rx_pin;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx_pin, o_irq;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata, d;
  logic        dominant = 1'h0;
  logic        tick_en = 1'h0;
  int          fail_count = 0;
  int          num_checks = 0;

  sbac_arbiter i_sbac_arbiter (.i_clock, .i_reset_n, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_rx_pin,
    .i_internal_transmit_out, .i_prescaler_tick, .o_tx_pin, .o_irq);
  sbac_bus_node i_sbac_bus_node (.i_clock, .i_tx_pin(o_tx_pin), .i_dominant(dominant),
    .o_rx_pin(i_rx_pin));

  // clock and prescaler pulse every second cycle
  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) i_prescaler_tick <= tick_en & ~i_prescaler_tick;

  // ====================
  // tasks
  task automatic close_out;
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // bounded wait for a handshake signal
  task automatic await(ref logic s);
    int n;
    n = 0;
    // always let the request edge pass before sampling the answer
    do begin
      @(posedge i_clock);
      n++;
      if (n > 50) begin
        fail_count++;
        close_out();
      end
    end while (s !== 1'h1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= v;
    i_wstrb <= s;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    await(o_awready);
    i_awvalid <= 1'h0;
    i_wvalid <= 1'h0;
    await(o_bvalid);
    i_bready <= 1'h0;
    ck("bresp", {30'h0, o_bresp}, 32'h0);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    await(o_arready);
    i_arvalid <= 1'h0;
    await(o_rvalid);
    i_rready <= 1'h0;
    d = o_rdata;
  endtask
  task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    rd(a);
    ck(nm, d & m, e);
  endtask
  // short dominant pulse from another node
  task automatic dp;
    @(posedge i_clock);
    dominant <= 1'h1;
    cyc(4);
    dominant <= 1'h0;
  endtask

  // ====================
  // sequence
  initial begin
    cyc(5);
    i_reset_n <= 1'h1;
    rc("control", 4'h0, 32'h7ff, 32'h0);
    rc("count", 4'h4, 32'hff, 32'h0);
    ck("tx idle", {31'h0, o_tx_pin}, 32'h1);
    // bit time, bus clock / 4, done interrupt enabled
    wr(4'h0, 32'h140, 4'h3);
    dp();
    cyc(90);
    rc("running", 4'h0, 32'h4, 32'h4);
    cyc(90);
    dp();
    cyc(20);
    dp();
    cyc(20);
    rc("done", 4'h0, 32'hf, 32'h8);
    rd(4'h4);
    ck("period", {31'h0, d[7:0] >= 8'h2c && d[7:0] <= 8'h34}, 32'h1);
    ck("irq", {31'h0, o_irq}, 32'h1);
    rc("status", 4'h8, 32'h7, 32'h1);
    wr(4'h0, 32'h0, 4'h2);
    ck("masked", {31'h0, o_irq}, 32'h0);
    wr(4'hc, 32'h1, 4'hf);
    rc("cleared", 4'h8, 32'h7, 32'h0);
    wr(4'h0, 32'h40, 4'h1);
    rc("ctl wipe", 4'h0, 32'hf, 32'h0);
    rc("cnt wipe", 4'h4, 32'hff, 32'h0);
    // overflow after 512 counts
    dp();
    cyc(2100);
    rc("overflow", 4'h0, 32'h6, 32'h6);
    wr(4'h0, 32'h0, 4'h1);
    rc("idle", 4'h0, 32'hf, 32'h0);
    dp();
    cyc(20);
    rc("idle cnt", 4'h4, 32'hff, 32'h0);
    // break length, prescaler clock, line already low
    tick_en <= 1'h1;
    dominant <= 1'h1;
    cyc(5);
    wr(4'h0, 32'h50, 4'h1);
    cyc(100);
    dominant <= 1'h0;
    cyc(20);
    rc("break", 4'h0, 32'h1c, 32'h18);
    rd(4'h4);
    ck("break len", {31'h0, d[7:0] >= 8'h16 && d[7:0] <= 8'h1e}, 32'h1);
    // arbitration lost, lost interrupt enabled
    wr(4'h0, 32'h480, 4'h3);
    i_internal_transmit_out <= 1'h0;
    cyc(4);
    i_internal_transmit_out <= 1'h1;
    dominant <= 1'h1;
    cyc(150);
    rc("early", 4'h0, 32'h20, 32'h0);
    cyc(150);
    rc("lost", 4'h0, 32'h20, 32'h20);
    ck("lost irq", {31'h0, o_irq}, 32'h1);
    i_internal_transmit_out <= 1'h0;
    cyc(4);
    ck("forced", {31'h0, o_tx_pin}, 32'h1);
    wr(4'h0, 32'h0, 4'h1);
    cyc(3);
    rc("unlost", 4'h0, 32'h20, 32'h0);
    ck("released", {31'h0, o_tx_pin}, 32'h0);
    // arbitration won, prescaler clock, then early low
    dominant <= 1'h0;
    wr(4'h0, 32'h90, 4'h1);
    i_internal_transmit_out <= 1'h1;
    cyc(80);
    rc("won", 4'h0, 32'h20, 32'h0);
    rc("sample pt", 4'h4, 32'hff, 32'h8);
    i_internal_transmit_out <= 1'h0;
    cyc(5);
    i_internal_transmit_out <= 1'h1;
    cyc(12);
    i_internal_transmit_out <= 1'h0;
    cyc(10);
    rc("restart", 4'h4, 32'hff, 32'h0);
    rc("stopped", 4'h0, 32'h24, 32'h0);
    close_out();
  end
endmodule
